/* File: pclo_pkg.sv */
package pclo_pkg;
   // Processor I/O port map
   localparam logic [7:0] PALETTE_BASE    = 8'h18;
   localparam int         PALETTE_ENTRIES = 4;
   localparam logic [7:0] PALETTE_RESET   = 8'h00;
   // Screen geometry and shift register length
   localparam int         SCREEN_COLS     = 768;
   localparam int         SCREEN_ROWS     = 256;
   localparam int         SHIFT_BITS      = 12;
   // Palette byte field positions
   localparam int         MONO_LSB        = 0;
   localparam int         RED_LSB         = 2;
   localparam int         GREEN_LSB       = 4;
   localparam int         BLUE_LSB        = 6;
   // Monochrome intensity codes
   localparam logic [1:0] MONO_DARK       = 2'h0;
   localparam logic [1:0] MONO_DIM        = 2'h1;
   localparam logic [1:0] MONO_NORMAL     = 2'h2;
   localparam logic [1:0] MONO_BOLD       = 2'h3;
   // Pixel FIFO
   localparam int         FIFO_DEPTH      = 16;
   localparam int         PIX_W           = 2 * SHIFT_BITS;
endpackage : pclo_pkg

/* File: pclo_word_if.sv */
`timescale 1ns/100ps
interface pclo_word_if #(parameter int WIDTH = 24);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : pclo_word_if

/* File: pclo_fifo.sv */
`timescale 1ns/100ps
module pclo_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Ports
   pclo_word_if.snk in_w,
   pclo_word_if.src out_w
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_w.ready  = (count != (AW+1)'(DEPTH));
   assign out_w.valid = (count != '0);
   assign out_w.data  = mem[rd_ptr];
   assign push        = in_w.valid && in_w.ready;
   assign pop         = out_w.valid && out_w.ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_w.data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
      count <= (AW+1)'(DEPTH)) else $error("FIFO count over depth");
endmodule : pclo_fifo

/* File: pclo_palette_out.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Each screen location of 768 by 256 holds two bits, one per plane, written singly or paired.
// - A pixel's two bits decode as a value 0 to 3 choosing one of four palette entries.
// - The palette is four bytes indexed by the pixel value during refresh, feeding the converters.
// - Two bits of each byte give monochrome intensity dark, dim, normal or bold.
// - Two bits per red, green and blue gun give four levels each and 64 colours.
// - The pixel pair addresses the palette and the byte is latched on the next pixel strobe.
// - The latched byte holds for a full pixel period while the next pixel addresses the palette.
// - Each latched two-bit field drives its converter as two independent switch controls.
// - Twelve bits per plane load at count 0, the select then going high for the first bit shown, then 11 shift out.
////////////////////////////////////////////////////////////////////////////////
module pclo_palette_out #(
   parameter int DEPTH = pclo_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Processor I/O write port
   input  wire logic [7:0]  io_addr,
   input  wire logic [7:0]  io_wdata,
   input  wire logic        io_wr,
   // Bit map words, one per plane
   input  wire logic [11:0] word_low,
   input  wire logic [11:0] word_high,
   input  wire logic        word_valid,
   output logic             word_ready,
   // Pixel timing
   input  wire logic        pixel_strobe,
   // Converter switch controls, shift load select and pixel plane bits
   output logic [1:0]       mono_sw,
   output logic [1:0]       red_sw,
   output logic [1:0]       green_sw,
   output logic [1:0]       blue_sw,
   output logic             shift_load_select,
   output logic             pixel_plane_bit_low,
   output logic             pixel_plane_bit_high
);
   localparam int PW = pclo_pkg::PIX_W;
   if (DEPTH != pclo_pkg::FIFO_DEPTH) begin : g_bad_depth
      $error("Pixel FIFO depth must be 16");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised strobe and pixel word FIFO
   logic strobe_s1;
   logic strobe_s2;
   logic strobe_d;
   logic tick;
   always_ff @(posedge clk) begin
      if (rst) begin
         strobe_s1 <= 1'b0;
         strobe_s2 <= 1'b0;
         strobe_d  <= 1'b0;
      end else begin
         strobe_s1 <= pixel_strobe;
         strobe_s2 <= strobe_s1;
         strobe_d  <= strobe_s2;
      end
   end
   assign tick = strobe_s2 && !strobe_d;

   pclo_word_if #(.WIDTH(PW)) wr_w ();
   pclo_word_if #(.WIDTH(PW)) rd_w ();
   assign wr_w.data  = {word_high, word_low};
   // Only words handed over under word_ready enter the FIFO
   assign wr_w.valid = word_valid && word_ready;

   pclo_fifo #(.WIDTH(PW), .DEPTH(DEPTH)) u_fifo (
      .clk   (clk),
      .rst   (rst),
      .in_w  (wr_w.snk),
      .out_w (rd_w.src)
   );

   always_ff @(posedge clk) begin
      if (rst) word_ready <= 1'b0;
      else     word_ready <= wr_w.ready && !(word_valid && word_ready);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Palette memory, written by the processor
   logic [7:0] palette [pclo_pkg::PALETTE_ENTRIES];

   function automatic logic hit(input logic [7:0] a);
      hit = (a[7:2] == pclo_pkg::PALETTE_BASE[7:2]);
   endfunction : hit

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < pclo_pkg::PALETTE_ENTRIES; i++) begin
            palette[i] <= pclo_pkg::PALETTE_RESET;
         end
      end else if (io_wr && hit(io_addr)) begin
         palette[io_addr[1:0]] <= io_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Twin plane shift registers
   logic [11:0] sh_low;
   logic [11:0] sh_high;
   logic [3:0]  bit_cnt;
   logic        loaded;
   logic        take;
   assign take = tick && (bit_cnt == 4'h0) && rd_w.valid && !rd_w.ready;

   // Count 0 loads a word, 1 to 11 shift
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_cnt <= '0;
      end else if (tick) begin
         if (bit_cnt == 4'(pclo_pkg::SHIFT_BITS - 1)) begin
            bit_cnt <= 4'h0;
         end else begin
            bit_cnt <= bit_cnt + 4'h1;
         end
      end
   end

   // Pop pulse and load flag
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_w.ready <= 1'b0;
         loaded     <= 1'b0;
      end else begin
         rd_w.ready <= take;
         if (tick && bit_cnt == 4'h0) loaded <= take;
      end
   end

   // Plane shift registers
   always_ff @(posedge clk) begin
      if (rst) begin
         sh_low  <= '0;
         sh_high <= '0;
      end else if (take) begin
         sh_low  <= rd_w.data[11:0];
         sh_high <= rd_w.data[23:12];
      end else if (tick && bit_cnt == 4'h0) begin
         sh_low  <= '0;
         sh_high <= '0;
      end else if (tick) begin
         sh_low  <= sh_low >> 1;
         sh_high <= sh_high >> 1;
      end
   end
   logic [1:0] pix;
   assign pix = {sh_high[0], sh_low[0]};

   ////////////////////////////////////////////////////////////////////////////
   // Output latch
   logic [7:0] sel;
   assign sel = palette[pix];
   always_ff @(posedge clk) begin
      if (rst) begin
         mono_sw  <= pclo_pkg::MONO_DARK;
         red_sw   <= '0;
         green_sw <= '0;
         blue_sw  <= '0;
      end else if (tick) begin
         mono_sw  <= sel[pclo_pkg::MONO_LSB +: 2];
         red_sw   <= sel[pclo_pkg::RED_LSB +: 2];
         green_sw <= sel[pclo_pkg::GREEN_LSB +: 2];
         blue_sw  <= sel[pclo_pkg::BLUE_LSB +: 2];
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         shift_load_select    <= 1'b0;
         pixel_plane_bit_low  <= 1'b0;
         pixel_plane_bit_high <= 1'b0;
      end else begin
         shift_load_select    <= (bit_cnt == 4'h1) && loaded;
         pixel_plane_bit_low  <= pix[0];
         pixel_plane_bit_high <= pix[1];
      end
   end


   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_latch_hold: assert property (@(posedge clk) disable iff (rst)
      !tick |=> $stable(mono_sw) && $stable(blue_sw)) else $error("Latch moved off strobe");
   a_latch_take: assert property (@(posedge clk) disable iff (rst)
      tick |=> {blue_sw, green_sw, red_sw, mono_sw} == $past(sel)) else $error("Wrong byte");
   a_pal_write: assert property (@(posedge clk) disable iff (rst)
      io_wr && hit(io_addr) |=> palette[$past(io_addr[1:0])] == $past(io_wdata))
      else $error("Palette write lost");
   a_pal_ignore: assert property (@(posedge clk) disable iff (rst)
      !(io_wr && hit(io_addr)) |=> $stable(palette[0]) && $stable(palette[1])
         && $stable(palette[2]) && $stable(palette[3])) else $error("Palette changed unasked");
   a_shift_step: assert property (@(posedge clk) disable iff (rst)
      tick && bit_cnt != 4'h0 |=> sh_low == ($past(sh_low) >> 1)
         && sh_high == ($past(sh_high) >> 1)) else $error("Shift step wrong");
   a_pal_nostall: assert property (@(posedge clk) disable iff (rst)
      tick |=> bit_cnt != $past(bit_cnt)) else $error("Pixel stalled");
   a_fifo_pop: assert property (@(posedge clk) disable iff (rst)
      rd_w.ready |-> $past(tick) && bit_cnt == 4'h1) else $error("Pop out of place");
   a_load_word: assert property (@(posedge clk) disable iff (rst)
      take |=> {sh_high, sh_low} == $past(rd_w.data)) else $error("Word not loaded");
   a_empty_zero: assert property (@(posedge clk) disable iff (rst)
      tick && bit_cnt == 4'h0 && !rd_w.valid |=> sh_low == '0 && sh_high == '0)
      else $error("Idle pixels not zero");
   a_cnt_range: assert property (@(posedge clk) disable iff (rst)
      bit_cnt <= 4'(pclo_pkg::SHIFT_BITS - 1)) else $error("Pixel count out of range");
   a_load_flag: assert property (@(posedge clk) disable iff (rst)
      shift_load_select |-> $past(bit_cnt) == 4'h1 && $past(loaded))
      else $error("Load flag misplaced");
   a_ready_room: assert property (@(posedge clk) disable iff (rst)
      word_ready |-> wr_w.ready) else $error("Word offered with FIFO full");
   a_pixel_idx: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> {pixel_plane_bit_high, pixel_plane_bit_low} == $past(pix))
      else $error("Pixel index lag");
   a_latch_quiet: assert property (@(posedge clk) disable iff (rst)
      !tick |=> $stable(red_sw) && $stable(green_sw)) else $error("Colour latch moved");
endmodule : pclo_palette_out

/* File: pclo_dac_model.sv */
`timescale 1ns/100ps
// Converters: two weighted switches per gun and for monochrome
module pclo_dac_model (
   // Switch controls
   input  wire logic [1:0] mono_sw,
   input  wire logic [1:0] red_sw,
   input  wire logic [1:0] green_sw,
   input  wire logic [1:0] blue_sw,
   // Drive levels
   output logic [7:0]      levels
);
   function automatic logic [1:0] lvl(input logic [1:0] sw);
      return (sw[1] ? 2'h2 : 2'h0) + (sw[0] ? 2'h1 : 2'h0);
   endfunction : lvl
   assign levels = {lvl(blue_sw), lvl(green_sw), lvl(red_sw), lvl(mono_sw)};
endmodule : pclo_dac_model

/* File: test_pixel_color_lookup_output.sv */
`timescale 1ns/100ps
module test_pixel_color_lookup_output;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  io_addr, io_wdata, levels, snap;
   logic        io_wr, word_valid, pixel_strobe, word_ready, ok;
   logic [11:0] word_low, word_high;
   logic [1:0]  mono_sw, red_sw, green_sw, blue_sw;
   logic        shift_load_select, pixel_plane_bit_low, pixel_plane_bit_high;
   logic [7:0]  pal [4];
   wire  [1:0]  shown = {pixel_plane_bit_high, pixel_plane_bit_low};
   localparam logic [11:0] PAT_LO = 12'hc35;
   localparam logic [11:0] PAT_HI = 12'h9a6;
   int          n_mismatch = 0, compares = 0, cyc = 0, n_load = 0, n;
   always #10 clk = ~clk;
   pclo_palette_out #(.DEPTH(pclo_pkg::FIFO_DEPTH)) u_pclo_palette_out (.clk(clk), .rst(rst),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .word_low(word_low),
      .word_high(word_high), .word_valid(word_valid), .word_ready(word_ready),
      .pixel_strobe(pixel_strobe), .mono_sw(mono_sw), .red_sw(red_sw), .green_sw(green_sw),
      .blue_sw(blue_sw), .shift_load_select(shift_load_select),
      .pixel_plane_bit_low(pixel_plane_bit_low), .pixel_plane_bit_high(pixel_plane_bit_high));
   pclo_dac_model u_pclo_dac_model (.mono_sw(mono_sw), .red_sw(red_sw), .green_sw(green_sw),
      .blue_sw(blue_sw), .levels(levels));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   // Holds the write strobe; caller lowers it after the last write
   task automatic io_write(input logic [7:0] a, input logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
   endtask : io_write
   task automatic tick;
      pixel_strobe = 1'b1;
      repeat (4) @(negedge clk);
      snap = levels;
      pixel_strobe = 1'b0;
      repeat (3) @(negedge clk);
      check(levels, snap, "hold");
   endtask : tick
   task automatic push(input logic [11:0] lo, input logic [11:0] hi, output logic acc);
      acc = 1'b0;
      word_low = lo;
      word_high = hi;
      word_valid = 1'b1;
      for (int i = 0; i < 4 && !acc; i++) begin
         if (word_ready === 1'b1) acc = 1'b1;
         @(negedge clk);
      end
      word_valid = 1'b0;
      @(negedge clk);
   endtask : push
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (shift_load_select === 1'b1) n_load <= n_load + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         give_verdict;
      end
   end
   initial begin
      {io_addr, io_wdata, io_wr, word_low, word_high, word_valid, pixel_strobe} = '0;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      check(levels, 8'h00, "reset");
      $display("test reset done");
      pal = '{8'h1b, 8'h6c, 8'hb1, 8'he4};
      for (int i = 0; i < 4; i++) io_write(pclo_pkg::PALETTE_BASE + 8'(i), pal[i]);
      io_write(8'h17, 8'hff);
      io_write(8'h1c, 8'hff);
      io_wr = 1'b0;
      $display("test palette load done");
      for (int v = 0; v < 4; v++) begin
         repeat (3) push({12{v[0]}}, {12{v[1]}}, ok);
         repeat (14) tick;
         if (v == 2) begin
            io_write(8'h1a, 8'h5a);
            io_wr = 1'b0;
            pal[2] = 8'h5a;
            tick;
         end
         tick;
         check({6'h0, pixel_plane_bit_high, pixel_plane_bit_low}, 8'(v), "pixel");
         check(levels, pal[v], "colour");
         repeat (40) tick;
      end
      check(8'(n_load > 0), 8'h01, "load seen");
      $display("test pixel path done");
      n = 0;
      ok = 1'b1;
      while (ok && n < 20) begin
         push(12'hfff, 12'hfff, ok);
         if (ok) n++;
      end
      check(8'(n >= pclo_pkg::FIFO_DEPTH && n <= pclo_pkg::FIFO_DEPTH + 1), 8'h01, "fill");
      check(8'(word_ready), 8'h00, "refused");
      repeat (12 * (pclo_pkg::FIFO_DEPTH + 2) + 14) tick;
      check({6'h0, pixel_plane_bit_high, pixel_plane_bit_low}, 8'h00, "empty");
      check(levels, pal[0], "empty colour");
      $display("test fifo fill and drain done");
      push(PAT_LO, PAT_HI, ok);
      check(8'(ok), 8'h01, "pattern taken");
      for (int i = 0; i < 13 && pixel_plane_bit_low !== 1'b1; i++) tick;
      check(8'(shown), 8'({PAT_HI[0], PAT_LO[0]}), "first");
      for (int i = 1; i < pclo_pkg::SHIFT_BITS; i++) begin
         tick;
         check(8'(shown), 8'({PAT_HI[i], PAT_LO[i]}), "order");
         check(levels, pal[{PAT_HI[i-1], PAT_LO[i-1]}], "lookup");
      end
      $display("test bit order done");
      give_verdict;
   end
endmodule : test_pixel_color_lookup_output
